//--- gsa_cpl_model.sv
// completion acceptor standing in for the requesting side
`timescale 1ns/10ps
`default_nettype none
module gsa_cpl_model (
   input wire logic i_clk,
   input wire logic i_rsp_valid,
   input wire logic i_drop,
   input wire logic [3:0] i_lag,
   output logic o_rsp_ready
);
   logic [3:0] wait_q;
   initial begin
      o_rsp_ready = 1'b0;
      wait_q = 4'h0;
   end
   // -------------------------------------------------------------
   // acceptance
   // -------------------------------------------------------------
   // prompt, slow or never accepted
   always @(negedge i_clk) begin
      if (!i_rsp_valid || o_rsp_ready) begin
         o_rsp_ready <= 1'b0;
         wait_q <= 4'h0;
      end else if (!i_drop && wait_q >= i_lag) begin
         o_rsp_ready <= 1'b1;
      end else begin
         wait_q <= wait_q + 4'h1;
      end
   end
endmodule // gsa_cpl_model
`default_nettype wire

//--- gsa_global_space.sv
// global register space decode, indirect access and delayed side effects
// Operation
// - one 18-bit, 256 KB global register space
// - sixteen bridge regions, 0x02000 apart, 4 KB
// - switch region at 0x3E000 through 0x3FFFF
// - reserved global ranges: reads zero, writes complete
// - cfg requests see bridge as function 0
// - indirect address is DWord index, data accesses
// - indirect pair reaches every register except ext cfg window and indirect data
// - protect bit disables indirect pair, reads zero
// - smbus and eeprom ignore protect mask
// - completion first, side effect 1 ms later
// - delay applies to reset trigger, mode field
// - bridge offsets: base, extended, vendor areas
// - bridge registers reachable by cfg in upstream and downstream mode only
// - ext cfg window unreachable through indirect pair
// - bridge reserved offsets read zero, writes dropped
// - register presence depends on port mode
// - absent registers behave as reserved
`timescale 1ns/10ps
`default_nettype none
module gsa_global_space #(
   parameter int SE_DELAY_CYCLES = gsa_pkg::SE_DELAY_CYC
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_req_valid,
   input wire gsa_pkg::gsa_req_type i_req,
   output logic o_req_ready,
   output logic o_rsp_valid,
   output gsa_pkg::gsa_rsp_type o_rsp,
   input wire logic i_rsp_ready,
   output logic [gsa_pkg::NUM_PORTS-1:0][1:0] o_port_mode,
   output logic [gsa_pkg::NUM_PORTS-1:0] o_flr_pulse,
   output logic o_se_pending
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   gsa_pkg::gsa_state_type state_q, state_d;
   gsa_pkg::gsa_kind_type kind_q, kind_d;
   logic [gsa_pkg::PORT_W-1:0] rport_q, rport_d;
   logic zero_q, zero_d, err_q, err_d, rsp_se_q, rsp_se_d;
   gsa_pkg::gsa_rsp_type rsp_q, rsp_d;
   logic [gsa_pkg::NUM_PORTS-1:0] prot_q, prot_d;
   logic [gsa_pkg::NUM_PORTS-1:0][1:0] mode_q, mode_d;
   logic [gsa_pkg::NUM_PORTS-1:0][15:0] ind_q, ind_d;
   logic se_pend_q, se_pend_d, se_flr_q, se_flr_d;
   logic [gsa_pkg::PORT_W-1:0] se_port_q, se_port_d;
   logic [1:0] se_mode_q, se_mode_d;
   logic [gsa_pkg::SE_CNT_W-1:0] se_cnt_q, se_cnt_d;
   logic [gsa_pkg::NUM_PORTS-1:0] flr_q, flr_d;

   // ---------------------------------------------------------------
   // request decode
   // ---------------------------------------------------------------
   logic is_cfg, cfg_bad, prot_hit, acc, se_hit, se_fire, mem_we;
   logic [17:0] daddr, eaddr;
   gsa_pkg::gsa_kind_type dkind, ekind;
   logic [gsa_pkg::DATA_W-1:0] mem_wdata, mem_rdata;

   always_comb begin
      is_cfg = i_req.src == gsa_pkg::SRC_CFG;
      daddr = is_cfg ? {1'b0, i_req.port, 1'b0, i_req.addr[11:0]}
                     : i_req.addr;
      dkind = gsa_pkg::classify(daddr, mode_q[daddr[16:13]]);
      cfg_bad = is_cfg && mode_q[i_req.port] != gsa_pkg::UPSTREAM_PORT_MODE
                && mode_q[i_req.port] != gsa_pkg::DOWNSTREAM_PORT_MODE;
      prot_hit = is_cfg && prot_q[i_req.port] &&
                 (dkind == gsa_pkg::K_IND_ADDR ||
                  dkind == gsa_pkg::K_IND_DATA);
      eaddr = daddr;
      ekind = dkind;
      if (dkind == gsa_pkg::K_IND_DATA) begin
         eaddr = {ind_q[daddr[16:13]], 2'b00};
         ekind = gsa_pkg::classify(eaddr, mode_q[eaddr[16:13]]);
         if (ekind == gsa_pkg::K_ECFG || ekind == gsa_pkg::K_IND_DATA) begin
            ekind = gsa_pkg::K_RSVD;
         end
      end
      if (prot_hit || cfg_bad) begin
         ekind = gsa_pkg::K_RSVD;
      end
      se_hit = i_req.write && i_req.be[0] &&
               ((ekind == gsa_pkg::K_PORTCTL) ||
                (ekind == gsa_pkg::K_MEM && eaddr < gsa_pkg::RSVD_BASE &&
                 eaddr[11:0] == gsa_pkg::PHY_LS_OFF &&
                 (i_req.wdata & gsa_pkg::FLR_MASK) != 32'h0000_0000));
      // one delayed action in flight; a second one waits
      o_req_ready = state_q == gsa_pkg::ST_IDLE && !(se_hit && se_pend_q);
      acc = i_req_valid && o_req_ready;
      mem_we = acc && i_req.write && (ekind == gsa_pkg::K_MEM ||
                                      ekind == gsa_pkg::K_ECFG);
      // reset trigger is self clearing, never stored
      mem_wdata = i_req.wdata;
      if (eaddr[11:0] == gsa_pkg::PHY_LS_OFF) begin
         mem_wdata = i_req.wdata & ~gsa_pkg::FLR_MASK;
      end
   end

   gsa_reg_mem u_mem (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_we(mem_we),
      .i_be(i_req.be),
      .i_idx(eaddr[17:2]),
      .i_wdata(mem_wdata),
      .o_rdata(mem_rdata)
   );

   // ---------------------------------------------------------------
   // access sequencing and completion
   // ---------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      kind_d = kind_q;
      rport_d = rport_q;
      zero_d = zero_q;
      err_d = err_q;
      rsp_se_d = rsp_se_q;
      rsp_d = rsp_q;
      case (state_q)
         gsa_pkg::ST_IDLE: begin
            if (acc) begin
               state_d = gsa_pkg::ST_MEM;
               kind_d = ekind;
               rport_d = (ekind == gsa_pkg::K_PORTCTL) ? eaddr[5:2]
                                                        : eaddr[16:13];
               zero_d = i_req.write;
               err_d = cfg_bad;
               rsp_se_d = se_hit && is_cfg;
            end
         end
         gsa_pkg::ST_MEM: begin
            state_d = gsa_pkg::ST_RESP;
            rsp_d.err = err_q;
            rsp_d.rdata = 32'h0000_0000;
            if (!zero_q) begin
               case (kind_q)
                  gsa_pkg::K_MEM, gsa_pkg::K_ECFG: rsp_d.rdata = mem_rdata;
                  gsa_pkg::K_IND_ADDR:
                     rsp_d.rdata = {14'h0, ind_q[rport_q], 2'b00};
                  gsa_pkg::K_PROT: rsp_d.rdata = {16'h0000, prot_q};
                  gsa_pkg::K_PORTCTL: rsp_d.rdata = {30'h0, mode_q[rport_q]};
                  default: rsp_d.rdata = 32'h0000_0000;
               endcase
            end
         end
         gsa_pkg::ST_RESP: begin
            if (i_rsp_ready || (se_fire && rsp_se_q)) begin
               state_d = gsa_pkg::ST_IDLE;
            end
         end
         default: state_d = gsa_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_q <= gsa_pkg::ST_IDLE;
         kind_q <= gsa_pkg::K_RSVD;
         rport_q <= 4'h0;
         zero_q <= 1'b0;
         err_q <= 1'b0;
         rsp_se_q <= 1'b0;
         rsp_q <= '0;
      end else begin
         state_q <= state_d;
         kind_q <= kind_d;
         rport_q <= rport_d;
         zero_q <= zero_d;
         err_q <= err_d;
         rsp_se_q <= rsp_se_d;
         rsp_q <= rsp_d;
      end
   end

   assign o_rsp_valid = state_q == gsa_pkg::ST_RESP;
   assign o_rsp = rsp_q;

   // ---------------------------------------------------------------
   // flop registers: protect mask, indirect address, port mode
   // ---------------------------------------------------------------
   always_comb begin
      prot_d = prot_q;
      ind_d = ind_q;
      mode_d = mode_q;
      if (acc && i_req.write) begin
         case (ekind)
            gsa_pkg::K_PROT: begin
               if (i_req.be[0]) prot_d[7:0] = i_req.wdata[7:0];
               if (i_req.be[1]) prot_d[15:8] = i_req.wdata[15:8];
            end
            gsa_pkg::K_IND_ADDR: ind_d[eaddr[16:13]] = i_req.wdata[17:2];
            default: ind_d = ind_q;
         endcase
      end
      if (se_fire && !se_flr_q) begin
         mode_d[se_port_q] = se_mode_q;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         prot_q <= 16'h0000;
         ind_q <= '0;
         mode_q <= gsa_pkg::MODE_RST;
      end else begin
         prot_q <= prot_d;
         ind_q <= ind_d;
         mode_q <= mode_d;
      end
   end

   assign o_port_mode = mode_q;

   // ---------------------------------------------------------------
   // delayed side effect
   // ---------------------------------------------------------------
   assign se_fire = se_pend_q &&
                    se_cnt_q == gsa_pkg::SE_CNT_W'(SE_DELAY_CYCLES - 1);

   always_comb begin
      se_pend_d = se_pend_q;
      se_flr_d = se_flr_q;
      se_port_d = se_port_q;
      se_mode_d = se_mode_q;
      se_cnt_d = se_cnt_q;
      flr_d = '0;
      if (se_fire) begin
         se_pend_d = 1'b0;
         se_cnt_d = '0;
         if (se_flr_q) flr_d[se_port_q] = 1'b1;
      end else if (se_pend_q) begin
         se_cnt_d = se_cnt_q + 1'b1;
      end
      if (acc && se_hit) begin
         se_pend_d = 1'b1;
         se_cnt_d = '0;
         se_flr_d = ekind != gsa_pkg::K_PORTCTL;
         se_port_d = (ekind == gsa_pkg::K_PORTCTL) ? eaddr[5:2]
                                                    : eaddr[16:13];
         se_mode_d = i_req.wdata[1:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         se_pend_q <= 1'b0;
         se_flr_q <= 1'b0;
         se_port_q <= 4'h0;
         se_mode_q <= 2'h0;
         se_cnt_q <= '0;
         flr_q <= '0;
      end else begin
         se_pend_q <= se_pend_d;
         se_flr_q <= se_flr_d;
         se_port_q <= se_port_d;
         se_mode_q <= se_mode_d;
         se_cnt_q <= se_cnt_d;
         flr_q <= flr_d;
      end
   end

   assign o_flr_pulse = flr_q;
   assign o_se_pending = se_pend_q;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   sequence accepted_read_s;
      acc && !i_req.write;
   endsequence
   sequence answer_s;
      ##2 o_rsp_valid;
   endsequence

   read_answer_a: assert property (accepted_read_s |-> answer_s)
      else $error("read answer not two cycles after accept");
   protect_zero_a: assert property (
      acc && prot_hit && !i_req.write |-> ##2 o_rsp.rdata == 32'h0000_0000)
      else $error("protected indirect read not zero");
   protect_src_a: assert property (
      acc && !is_cfg |-> !prot_hit)
      else $error("protect mask hit a non cfg request");
   window_block_a: assert property (
      acc && dkind == gsa_pkg::K_IND_DATA &&
      gsa_pkg::classify(eaddr, mode_q[eaddr[16:13]]) == gsa_pkg::K_ECFG
      |-> !mem_we)
      else $error("ext cfg window reached indirectly");
   reserved_zero_a: assert property (
      acc && !i_req.write && ekind == gsa_pkg::K_RSVD
      |-> ##2 o_rsp.rdata == 32'h0000_0000)
      else $error("reserved read not zero");
   func_zero_a: assert property (
      acc && cfg_bad |-> ##2 (o_rsp_valid && o_rsp.err))
      else $error("cfg to inactive port not flagged");
   delay_start_a: assert property (
      acc && se_hit |=> se_pend_q && se_cnt_q == '0 && !se_fire)
      else $error("side effect not deferred");
   mode_late_a: assert property (
      mode_q != $past(mode_q) |-> $past(se_fire) && !$past(se_flr_q))
      else $error("port mode changed without delay expiry");
   flr_late_a: assert property (
      o_flr_pulse != '0 |-> $past(se_fire) && $past(se_flr_q))
      else $error("reset trigger fired early");
   absent_slot_a: assert property (
      acc && !is_cfg && daddr < gsa_pkg::RSVD_BASE &&
      daddr[11:0] == gsa_pkg::SLOT_FIRST_OFF &&
      mode_q[daddr[16:13]] == gsa_pkg::UPSTREAM_PORT_MODE
      |-> dkind == gsa_pkg::K_RSVD)
      else $error("absent slot register not reserved");
endmodule // gsa_global_space
`default_nettype wire

//--- gsa_pkg.sv
// global space access constants, types and address decode
`default_nettype none
package gsa_pkg;

   // ---------------------------------------------------------------
   // widths and region layout
   // ---------------------------------------------------------------
   localparam int ADDR_W = 18;
   localparam int DATA_W = 32;
   localparam int NUM_PORTS = 16;
   localparam int PORT_W = 4;
   localparam int IDX_W = 16;
   localparam logic [17:0] PORT_STEP = 18'h02000;
   localparam logic [17:0] RSVD_BASE = 18'h20000;
   localparam logic [17:0] SW_BASE = 18'h3E000;
   localparam logic [11:0] BASE_CFG_END = 12'h0FF;
   localparam logic [11:0] EXT_CFG_END = 12'h3FF;
   localparam logic [11:0] BRIDGE_END = 12'hFFF;

   // ---------------------------------------------------------------
   // register offsets and fields
   // ---------------------------------------------------------------
   localparam logic [11:0] ECFG_ADDR_OFF = 12'h0F8;
   localparam logic [11:0] ECFG_DATA_OFF = 12'h0FC;
   localparam logic [11:0] SLOT_FIRST_OFF = 12'h054;
   localparam logic [11:0] SLOT_LAST_OFF = 12'h05B;
   localparam logic [11:0] PHY_LS_OFF = 12'h500;
   localparam logic [11:0] IND_ADDR_OFF = 12'hFF8;
   localparam logic [11:0] IND_DATA_OFF = 12'hFFC;
   localparam logic [12:0] PROT_OFF = 13'h0010;
   localparam logic [12:0] PORTCTL_BASE = 13'h0200;
   localparam logic [31:0] FLR_MASK = 32'h0000_0001;
   localparam logic [1:0] BYTE_ZERO = 2'h0;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int SE_DELAY_NS = 1000000;
   localparam int CLK_PERIOD_NS = 20;
   localparam int SE_DELAY_CYC = SE_DELAY_NS / CLK_PERIOD_NS;
   localparam int SE_CNT_W = 17;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      UPSTREAM_PORT_MODE = 2'h0,
      DOWNSTREAM_PORT_MODE = 2'h1,
      PORT_MODE_OFF = 2'h2
   } gsa_mode_type;

   typedef enum logic [1:0] {
      SRC_CFG = 2'h0,
      SRC_SMBUS = 2'h1,
      SRC_EEPROM = 2'h2
   } gsa_src_type;

   typedef enum logic [2:0] {
      K_MEM = 3'h0,
      K_IND_ADDR = 3'h1,
      K_IND_DATA = 3'h2,
      K_PROT = 3'h3,
      K_PORTCTL = 3'h4,
      K_RSVD = 3'h5,
      K_ECFG = 3'h6
   } gsa_kind_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_MEM = 2'h1,
      ST_RESP = 2'h3
   } gsa_state_type;

   // cfg requests give a port and a 12-bit offset, others a system address
   typedef struct packed {
      gsa_src_type src;
      logic [PORT_W-1:0] port;
      logic [ADDR_W-1:0] addr;
      logic write;
      logic [3:0] be;
      logic [DATA_W-1:0] wdata;
   } gsa_req_type;

   typedef struct packed {
      logic [DATA_W-1:0] rdata;
      logic err;
   } gsa_rsp_type;

   localparam logic [NUM_PORTS-1:0][1:0] MODE_RST =
      {{(NUM_PORTS-1){DOWNSTREAM_PORT_MODE}}, UPSTREAM_PORT_MODE};

   // ---------------------------------------------------------------
   // decode of a system address
   // ---------------------------------------------------------------
   function automatic gsa_kind_type classify(input logic [17:0] a,
                                             input logic [1:0] mode);
      gsa_kind_type k;
      k = K_MEM;
      if (a >= SW_BASE) begin
         if (a[12:0] == PROT_OFF) k = K_PROT;
         else if (a[12:6] == PORTCTL_BASE[12:6]) k = K_PORTCTL;
      end else if (a >= RSVD_BASE || a[12]) begin
         k = K_RSVD;
      end else if (a[11:2] == IND_ADDR_OFF[11:2]) begin
         k = K_IND_ADDR;
      end else if (a[11:2] == IND_DATA_OFF[11:2]) begin
         k = K_IND_DATA;
      end else if (a[11:2] == ECFG_ADDR_OFF[11:2] ||
                   a[11:2] == ECFG_DATA_OFF[11:2]) begin
         k = K_ECFG;
      end else if (a[11:0] >= SLOT_FIRST_OFF && a[11:0] <= SLOT_LAST_OFF &&
                   mode != DOWNSTREAM_PORT_MODE) begin
         k = K_RSVD;
      end
      return k;
   endfunction

endpackage
`default_nettype wire

//--- gsa_reg_mem.sv
// register storage for the global space, registered read data
`timescale 1ns/10ps
`default_nettype none
module gsa_reg_mem (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_we,
   input wire logic [3:0] i_be,
   input wire logic [gsa_pkg::IDX_W-1:0] i_idx,
   input wire logic [gsa_pkg::DATA_W-1:0] i_wdata,
   output logic [gsa_pkg::DATA_W-1:0] o_rdata
);
   logic [gsa_pkg::DATA_W-1:0] mem [2**gsa_pkg::IDX_W];
   logic [gsa_pkg::DATA_W-1:0] rdata_d;

   always_comb begin
      rdata_d = mem[i_idx];
   end

   // byte lanes written separately so narrow registers keep neighbours
   always_ff @(posedge i_clk) begin
      for (int b = 0; b < 4; b++) begin
         if (i_we && i_be[b]) begin
            mem[i_idx][8*b +: 8] <= i_wdata[8*b +: 8];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_rdata <= 32'h0000_0000;
      end else begin
         o_rdata <= rdata_d;
      end
   end
endmodule // gsa_reg_mem
`default_nettype wire

//--- testbench.sv
// self-checking bench for the global register space
`timescale 1ns/10ps
`default_nettype none
module testbench;
   localparam gsa_pkg::gsa_src_type SM = gsa_pkg::SRC_SMBUS;
   localparam gsa_pkg::gsa_src_type CF = gsa_pkg::SRC_CFG;
   localparam gsa_pkg::gsa_src_type EE = gsa_pkg::SRC_EEPROM;
   logic i_clk, i_sys_rst, i_req_valid, o_req_ready, o_rsp_valid;
   logic i_rsp_ready, o_se_pending, drop, er, got;
   gsa_pkg::gsa_req_type i_req;
   gsa_pkg::gsa_rsp_type o_rsp;
   logic [gsa_pkg::NUM_PORTS-1:0][1:0] o_port_mode;
   logic [gsa_pkg::NUM_PORTS-1:0] o_flr_pulse;
   logic [3:0] lag;
   logic [31:0] rd;
   int bad_count = 0;
   int checks_done = 0;
   int flr_cnt = 0;

   // short delay keeps the side-effect waits cheap
   gsa_global_space #(.SE_DELAY_CYCLES(20)) u_dut (.i_clk(i_clk),
      .i_sys_rst(i_sys_rst), .i_req_valid(i_req_valid), .i_req(i_req),
      .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp),
      .i_rsp_ready(i_rsp_ready), .o_port_mode(o_port_mode),
      .o_flr_pulse(o_flr_pulse), .o_se_pending(o_se_pending));
   gsa_cpl_model u_cpl (.i_clk(i_clk), .i_rsp_valid(o_rsp_valid),
      .i_drop(drop), .i_lag(lag), .o_rsp_ready(i_rsp_ready));

   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      if (o_flr_pulse[3] === 1'b1) flr_cnt <= flr_cnt + 1;
   end

   // -------------------------------------------------------------
   // tasks
   // -------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one request, held until taken, then wait for its completion
   task automatic xfer(input gsa_pkg::gsa_src_type src,
      input logic [3:0] port, input logic [17:0] addr, input logic wr,
      input logic [31:0] wd);
      int n;
      n = 0;
      rd = 32'hX;
      er = 1'bX;
      got = 1'b0;
      @(negedge i_clk);
      i_req_valid = 1'b1;
      i_req = '{src:src, port:port, addr:addr, write:wr, be:4'hF, wdata:wd};
      @(posedge i_clk);
      while (o_req_ready !== 1'b1 && n < 100) begin
         @(posedge i_clk);
         n++;
      end
      @(negedge i_clk);
      i_req_valid = 1'b0;
      n = 0;
      while (!got && n < 60) begin
         @(posedge i_clk);
         n++;
         if (o_rsp_valid === 1'b1 && i_rsp_ready === 1'b1) begin
            got = 1'b1;
            rd = o_rsp.rdata;
            er = o_rsp.err;
         end
      end
      if (!drop) check(got, 1'b1);
   endtask

   task automatic rdchk(input gsa_pkg::gsa_src_type src,
      input logic [3:0] port, input logic [17:0] addr,
      input logic [31:0] exp);
      xfer(src, port, addr, 1'b0, 32'h0);
      check(rd, exp);
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // -------------------------------------------------------------
   // tests
   // -------------------------------------------------------------
   initial begin
      i_sys_rst = 1'b1;
      i_req_valid = 1'b0;
      i_req = '0;
      drop = 1'b0;
      lag = 4'h0;
      repeat (20) @(posedge i_clk);
      @(negedge i_clk);
      i_sys_rst = 1'b0;
      check(o_port_mode, gsa_pkg::MODE_RST);
      check({o_se_pending, o_rsp_valid, o_req_ready}, 3'h1);
      for (int p = 0; p < 16; p++) begin
         xfer(SM, 4'h0, 18'(p) * 18'h02000 + 18'h00100, 1'b1,
            32'hA500_0000 + 32'(p));
         rdchk(CF, 4'(p), 18'h00100, 32'hA500_0000 + 32'(p));
      end
      rdchk(EE, 4'h0, 18'h1E100, 32'hA500_000F);
      xfer(SM, 4'h0, 18'h20000, 1'b1, 32'h1111_2222);
      check(got, 1'b1);
      rdchk(SM, 4'h0, 18'h3DFFC, 32'h0);
      xfer(SM, 4'h0, 18'h03000, 1'b1, 32'h3333_4444);
      rdchk(SM, 4'h0, 18'h03000, 32'h0);
      xfer(SM, 4'h0, 18'h00054, 1'b1, 32'h0000_1234);
      rdchk(SM, 4'h0, 18'h00054, 32'h0);
      xfer(SM, 4'h0, 18'h02054, 1'b1, 32'h0000_1234);
      rdchk(SM, 4'h0, 18'h02054, 32'h0000_1234);
      // indirect pair from port 1 into port 2's region
      xfer(CF, 4'h1, 18'h00FF8, 1'b1, 32'h0000_4100);
      rdchk(CF, 4'h1, 18'h00FF8, 32'h0000_4100);
      rdchk(CF, 4'h1, 18'h00FFC, 32'hA500_0002);
      xfer(CF, 4'h1, 18'h00FFC, 1'b1, 32'h5A5A_0001);
      rdchk(SM, 4'h0, 18'h04100, 32'h5A5A_0001);
      xfer(CF, 4'h1, 18'h00FF8, 1'b1, 32'h0000_00F8);
      rdchk(CF, 4'h1, 18'h00FFC, 32'h0);
      // protect port 1 only, pointer back on live data first
      xfer(CF, 4'h1, 18'h00FF8, 1'b1, 32'h0000_4100);
      xfer(SM, 4'h0, 18'h3E010, 1'b1, 32'h0000_0002);
      rdchk(CF, 4'h1, 18'h00FF8, 32'h0);
      rdchk(CF, 4'h1, 18'h00FFC, 32'h0);
      xfer(CF, 4'h1, 18'h00FFC, 1'b1, 32'hDEAD_0000);
      rdchk(SM, 4'h0, 18'h04100, 32'h5A5A_0001);
      rdchk(EE, 4'h0, 18'h3E010, 32'h0000_0002);
      rdchk(SM, 4'h0, 18'h02FFC, 32'h5A5A_0001);
      xfer(CF, 4'h2, 18'h00FF8, 1'b1, 32'h0000_4100);
      rdchk(CF, 4'h2, 18'h00FFC, 32'h5A5A_0001);
      xfer(SM, 4'h0, 18'h3E010, 1'b1, 32'h0);
      // delayed mode change, second one held off until first fires
      lag = 4'h3;
      xfer(SM, 4'h0, 18'h3E204, 1'b1, 32'h2);
      check(o_port_mode[1], 2'h1);
      check(o_se_pending, 1'b1);
      xfer(SM, 4'h0, 18'h3E204, 1'b1, 32'h1);
      lag = 4'h0;
      check(o_port_mode[1], 2'h2);
      xfer(CF, 4'h1, 18'h00100, 1'b0, 32'h0);
      check(er, 1'b1);
      rdchk(SM, 4'h0, 18'h02100, 32'hA500_0001);
      rdchk(SM, 4'h0, 18'h02054, 32'h0);
      repeat (25) @(posedge i_clk);
      check({o_se_pending, o_port_mode[1]}, 3'h1);
      // reset trigger on downstream port 3, then port 4 with its completion never taken
      xfer(CF, 4'h3, 18'h00500, 1'b1, 32'h1);
      check(flr_cnt, 0);
      repeat (25) @(posedge i_clk);
      check(flr_cnt, 1);
      @(negedge i_clk);
      drop = 1'b1;
      xfer(CF, 4'h4, 18'h00500, 1'b1, 32'h1);
      check({got, o_rsp_valid}, 2'h0);
      drop = 1'b0;
      report_and_stop();
   end

   // a hung handshake must not stall the run
   initial begin
      repeat (5000) @(posedge i_clk);
      bad_count++;
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
